//--- rtl/kmc_pkg.sv
// Shared constants, types and state layout of the keyboard/mouse controller
package kmc_pkg;
   // ---------------------------------------------------------------
   // Host ports and fixed values
   // ---------------------------------------------------------------
   localparam logic [7:0] PORT_DATA = 8'h60;
   localparam logic [7:0] PORT_CMD = 8'h64;
   localparam logic [7:0] CFG_RST = 8'h70;
   localparam logic [7:0] OUTP_RST = 8'h03;
   localparam logic [7:0] SELF_TEST_OK = 8'h55;
   localparam logic [7:0] IF_TEST_OK = 8'h00;
   localparam logic [1:0] INH_MODE_ON = 2'h1;

   // ---------------------------------------------------------------
   // Host command codes and ranges (upper nibble)
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_RD_CFG = 8'h20;
   localparam logic [7:0] CMD_WR_CFG = 8'h60;
   localparam logic [7:0] CMD_MS_OFF = 8'ha7;
   localparam logic [7:0] CMD_MS_ON = 8'ha8;
   localparam logic [7:0] CMD_MS_TEST = 8'ha9;
   localparam logic [7:0] CMD_SELF_TEST = 8'haa;
   localparam logic [7:0] CMD_KB_TEST = 8'hab;
   localparam logic [7:0] CMD_KB_OFF = 8'had;
   localparam logic [7:0] CMD_KB_ON = 8'hae;
   localparam logic [7:0] CMD_RD_INP = 8'hc0;
   localparam logic [7:0] CMD_RD_OUTP = 8'hd0;
   localparam logic [7:0] CMD_WR_OUTP = 8'hd1;
   localparam logic [7:0] CMD_TX_MS = 8'hd4;
   localparam logic [7:0] CMD_RD_TEST = 8'he0;
   localparam logic [3:0] GRP_RAM_RD = 4'h2;
   localparam logic [3:0] GRP_RAM_WR = 4'h6;
   localparam logic [3:0] GRP_PULSE = 4'hf;

   // ---------------------------------------------------------------
   // Bit positions
   // ---------------------------------------------------------------
   localparam int CFG_KB_IRQ = 0;
   localparam int CFG_MS_IRQ = 1;
   localparam int CFG_SYS = 2;
   localparam int CFG_INH_OVR = 3;
   localparam int CFG_KB_OFF = 4;
   localparam int CFG_MS_OFF = 5;
   localparam int OP_RST = 0;
   localparam int OP_A20 = 1;

   // ---------------------------------------------------------------
   // Timing and sizes
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PULSE_NS = 6000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int INH_US = 100;
   localparam int TMO_US = 2000;
   localparam int FRAME_BITS = 11;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 9;

   // Synchroniser lanes
   localparam int SY_KCLK = 0;
   localparam int SY_KDAT = 1;
   localparam int SY_MCLK = 2;
   localparam int SY_MDAT = 3;
   localparam int SY_INH = 4;
   localparam int SY_N = 5;
   localparam logic [SY_N-1:0] SY_IDLE = 5'h1f;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {E_IDLE, E_RX, E_TX_INH, E_TX_BITS, E_PULSE} kmc_eng_t;
   typedef enum logic [2:0] {AW_NONE, AW_CFG, AW_RAM, AW_OUTP, AW_MS} kmc_await_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } kmc_host_req_t;

   typedef struct packed {
      logic mouse;
      logic [7:0] data;
   } kmc_dev_byte_t;

   typedef struct packed {
      logic [SY_N-1:0] s1;
      logic [SY_N-1:0] s2;
      logic [SY_N-1:0] s3;
      logic [SY_N-1:0] lvl;
      logic [SY_N-1:0] fall;
   } kmc_sync_t;

   typedef struct packed {
      logic [7:0] obuf;
      logic obf;
      logic aux;
      logic [7:0] ibuf;
      logic ibf;
      logic cmd_last;
      logic tmo;
      logic [7:0] cfg;
      logic [7:0] ram;
      logic [7:0] outp;
      logic irq_kb;
      logic irq_ms;
      kmc_await_t await_st;
      kmc_eng_t eng;
      logic ch;
      logic [10:0] sr;
      logic [3:0] nbit;
      logic [17:0] tmr;
      logic [1:0] pmask;
      logic [7:0] rdata;
   } kmc_state_t;
endpackage

//--- rtl/kmc_sync.sv
// Three-stage synchroniser with agreement filter and falling-edge pulses
`timescale 1ns/1ns
module kmc_sync (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [kmc_pkg::SY_N-1:0] raw,
   output logic [kmc_pkg::SY_N-1:0] lvl,
   output logic [kmc_pkg::SY_N-1:0] fall
);
   kmc_pkg::kmc_sync_t q;
   kmc_pkg::kmc_sync_t d;

   // ---------------------------------------------------------------
   // Level follows only once stages two and three agree
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.s1 = raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
      d.fall = q.lvl & ~d.lvl;
   end

   // Lines idle high, so reset to high avoids a false edge
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         q.s1 <= kmc_pkg::SY_IDLE;
         q.s2 <= kmc_pkg::SY_IDLE;
         q.s3 <= kmc_pkg::SY_IDLE;
         q.lvl <= kmc_pkg::SY_IDLE;
         q.fall <= '0;
      end else begin
         q <= d;
      end
   end

   assign lvl = q.lvl;
   assign fall = q.fall;
endmodule

//--- rtl/kmc_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module kmc_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } kmc_fifo_st_t;
   kmc_fifo_st_t q;
   kmc_fifo_st_t d;
   logic push;
   logic pop;

   // ---------------------------------------------------------------
   // Pointer and count update
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Full refuses pushes even if a pop happens in the same cycle
   assign in_ready = (q.cnt != (AW+1)'(D));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
endmodule

//--- rtl/kmc_ctrl.sv
// Keyboard/mouse controller: host ports, command interpreter, serial engine
//
// How it works
// - Port 64h read returns status at any time; status is zero after reset except the inhibit bit.
// - Status bits: 7 zero, timeout, mouse data, inhibit, cmd/data, sysflag, IBF, OBF.
// - Writes to either port land in one input buffer; IBF set, cmd/data set for 64h and cleared for 60h.
// - One output buffer read at 60h; OBF flags data, bit 5 marks mouse.
// - Reading port 60h clears pending keyboard and mouse interrupt requests.
// - Data byte with no pending command goes to the keyboard.
// - Keyboard and mouse interrupt lines raise when enabled, held until 60h read.
// - Enabled inhibit pin low drops keyboard bytes unless config bit 3 overrides.
// - Commands finish at once, except keyboard and mouse transmits and pulse commands.
// - 20h reads config byte, 60h writes it next; reset value 70h.
// - 21h-2Fh read and 61h-6Fh write one scratch byte.
// - Config bits: mouse off, keyboard off, override, sysflag, mouse irq, kb irq.
// - A7h sets mouse-off and holds its clock low; A8h releases it.
// - ADh sets keyboard-off and holds its clock low; AEh releases it.
// - A9h and ABh return 00h, AAh returns 55h, no real test.
// - C0h returns inhibit pin, zeros, mouse data and keyboard data lines.
// - D0h returns irq bits 5 and 4 and output port bits 1:0.
// - D1h writes next data byte to output port; drives A20 mask and reset.
// - D4h sends next data byte to the mouse, paced by mouse clock.
// - E0h returns mouse clock in bit 1 and keyboard clock in bit 0.
// - F0h-FFh pulse low zero-selected output bits 0-1 for 6 us; low bits 11 (F3h, F7h, FBh, FFh) instant.
// - Frames are start 0, eight bits LSB first, odd parity, stop 1.
`timescale 1ns/1ns
module kmc_ctrl #(
   parameter int INH_CYC = kmc_pkg::INH_US * kmc_pkg::CLK_MHZ,
   parameter int TMO_CYC = kmc_pkg::TMO_US * kmc_pkg::CLK_MHZ
) (
   input wire logic mclk,
   input wire logic resetn,
   input kmc_pkg::kmc_host_req_t io_req,
   output logic [7:0] io_rdata,
   output logic keyboard_irq_line,
   output logic mouse_irq_line,
   output logic address_bit20_mask_n,
   output logic cpu_reset_req_n,
   input wire logic shared_inhibit_pin,
   input wire logic [1:0] inhibit_pin_mode,
   input wire logic kb_clk_i,
   output logic kb_clk_o,
   output logic kb_clk_oe,
   input wire logic kb_dat_i,
   output logic kb_dat_o,
   output logic kb_dat_oe,
   input wire logic ms_clk_i,
   output logic ms_clk_o,
   output logic ms_clk_oe,
   input wire logic ms_dat_i,
   output logic ms_dat_o,
   output logic ms_dat_oe
);
   localparam logic [17:0] INH_LAST = 18'(INH_CYC - 1);
   localparam logic [17:0] TMO_LAST = 18'(TMO_CYC - 1);
   localparam logic [17:0] PULSE_LAST = 18'(kmc_pkg::PULSE_CYC - 1);
   localparam logic [3:0] LAST_BIT = 4'(kmc_pkg::FRAME_BITS - 1);

   kmc_pkg::kmc_state_t q;
   kmc_pkg::kmc_state_t d;

   logic [kmc_pkg::SY_N-1:0] lvl;
   logic [kmc_pkg::SY_N-1:0] fall;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   kmc_pkg::kmc_dev_byte_t fifo_in;
   kmc_pkg::kmc_dev_byte_t fifo_out;
   logic inh_on;
   logic kb_drop;
   logic [7:0] status;
   logic resp_v;
   logic [7:0] resp_b;
   logic ch_fall;
   logic ch_dat;
   logic [10:0] rx_sr;
   logic busy;

   // Odd parity bit over a byte, used for sending; receive checks the XOR of data and parity
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~(^b);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and receive FIFO
   // ---------------------------------------------------------------
   kmc_sync u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .raw({shared_inhibit_pin, ms_dat_i, ms_clk_i, kb_dat_i, kb_clk_i}),
      .lvl(lvl),
      .fall(fall)
   );

   // Holds device bytes while the output buffer is still unread
   kmc_fifo #(
      .W(kmc_pkg::FIFO_W),
      .D(kmc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .resetn(resetn),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   // ---------------------------------------------------------------
   // Status and derived terms
   // ---------------------------------------------------------------
   assign inh_on = (inhibit_pin_mode == kmc_pkg::INH_MODE_ON);
   assign kb_drop = inh_on && !lvl[kmc_pkg::SY_INH] && !q.cfg[kmc_pkg::CFG_INH_OVR];
   // Inhibit bit reads zero while the pin function is off
   assign status = {1'b0, q.tmo, q.aux, inh_on && lvl[kmc_pkg::SY_INH], q.cmd_last,
                    q.cfg[kmc_pkg::CFG_SYS], q.ibf, q.obf};
   assign ch_fall = q.ch ? fall[kmc_pkg::SY_MCLK] : fall[kmc_pkg::SY_KCLK];
   assign ch_dat = q.ch ? lvl[kmc_pkg::SY_MDAT] : lvl[kmc_pkg::SY_KDAT];
   assign rx_sr = {ch_dat, q.sr[10:1]};
   assign busy = (q.eng == kmc_pkg::E_RX) || (q.eng == kmc_pkg::E_TX_BITS);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      resp_v = 1'b0;
      resp_b = '0;
      fifo_in_valid = 1'b0;
      fifo_in = '0;
      fifo_out_ready = 1'b0;

      // Host read: status any time, data read drains the buffer
      if (io_req.rd) begin
         if (io_req.addr == kmc_pkg::PORT_CMD) begin
            d.rdata = status;
         end else if (io_req.addr == kmc_pkg::PORT_DATA) begin
            d.rdata = q.obuf;
            d.obf = 1'b0;
            d.irq_kb = 1'b0;
            d.irq_ms = 1'b0;
         end
      end

      // Command processing; transmit and pulse keep the buffer full
      if (q.eng == kmc_pkg::E_IDLE && q.ibf) begin
         d.ibf = 1'b0;
         if (q.cmd_last) begin
            d.await_st = kmc_pkg::AW_NONE;
            case (q.ibuf)
               kmc_pkg::CMD_RD_CFG: begin
                  resp_v = 1'b1;
                  resp_b = q.cfg;
               end
               kmc_pkg::CMD_WR_CFG: d.await_st = kmc_pkg::AW_CFG;
               kmc_pkg::CMD_MS_OFF: d.cfg[kmc_pkg::CFG_MS_OFF] = 1'b1;
               kmc_pkg::CMD_MS_ON: d.cfg[kmc_pkg::CFG_MS_OFF] = 1'b0;
               kmc_pkg::CMD_KB_OFF: d.cfg[kmc_pkg::CFG_KB_OFF] = 1'b1;
               kmc_pkg::CMD_KB_ON: d.cfg[kmc_pkg::CFG_KB_OFF] = 1'b0;
               kmc_pkg::CMD_MS_TEST, kmc_pkg::CMD_KB_TEST: begin
                  resp_v = 1'b1;
                  resp_b = kmc_pkg::IF_TEST_OK;
               end
               kmc_pkg::CMD_SELF_TEST: begin
                  resp_v = 1'b1;
                  resp_b = kmc_pkg::SELF_TEST_OK;
               end
               kmc_pkg::CMD_RD_INP: begin
                  resp_v = 1'b1;
                  resp_b = {lvl[kmc_pkg::SY_INH], 5'h00, lvl[kmc_pkg::SY_MDAT],
                            lvl[kmc_pkg::SY_KDAT]};
               end
               kmc_pkg::CMD_RD_OUTP: begin
                  resp_v = 1'b1;
                  resp_b = {2'h0, q.irq_ms, q.irq_kb, 2'h0,
                            q.outp[kmc_pkg::OP_A20], q.outp[kmc_pkg::OP_RST]};
               end
               kmc_pkg::CMD_WR_OUTP: d.await_st = kmc_pkg::AW_OUTP;
               kmc_pkg::CMD_TX_MS: d.await_st = kmc_pkg::AW_MS;
               kmc_pkg::CMD_RD_TEST: begin
                  resp_v = 1'b1;
                  resp_b = {6'h00, lvl[kmc_pkg::SY_MCLK], lvl[kmc_pkg::SY_KCLK]};
               end
               default: begin
                  if (q.ibuf[7:4] == kmc_pkg::GRP_RAM_RD) begin
                     resp_v = 1'b1;
                     resp_b = q.ram;
                  end else if (q.ibuf[7:4] == kmc_pkg::GRP_RAM_WR) begin
                     d.await_st = kmc_pkg::AW_RAM;
                  end else if (q.ibuf[7:4] == kmc_pkg::GRP_PULSE && q.ibuf[1:0] != 2'h3) begin
                     // Unused bits 3:2 are ignored; all-ones ends at once
                     d.pmask = ~q.ibuf[1:0];
                     d.eng = kmc_pkg::E_PULSE;
                     d.tmr = '0;
                     d.ibf = 1'b1;
                  end
               end
            endcase
         end else begin
            d.await_st = kmc_pkg::AW_NONE;
            case (q.await_st)
               kmc_pkg::AW_CFG: d.cfg = q.ibuf;
               kmc_pkg::AW_RAM: d.ram = q.ibuf;
               kmc_pkg::AW_OUTP: d.outp = q.ibuf;
               default: begin
                  // Plain data goes to the keyboard, D4h data to the mouse
                  d.ch = (q.await_st == kmc_pkg::AW_MS);
                  d.sr = {1'b1, odd_par(q.ibuf), q.ibuf, 1'b0};
                  d.eng = kmc_pkg::E_TX_INH;
                  d.tmr = '0;
                  d.ibf = 1'b1;
               end
            endcase
         end
      end

      // Serial engine
      case (q.eng)
         kmc_pkg::E_IDLE: begin
            // A start needs data low too, so our own clock drive is no start
            if (!q.ibf && fifo_in_ready) begin
               if (fall[kmc_pkg::SY_KCLK] && !lvl[kmc_pkg::SY_KDAT] && !q.cfg[kmc_pkg::CFG_KB_OFF]) begin
                  d.eng = kmc_pkg::E_RX;
                  d.ch = 1'b0;
                  d.sr = {1'b0, 10'h000};
                  d.nbit = 4'h1;
                  d.tmr = '0;
               end else if (fall[kmc_pkg::SY_MCLK] && !lvl[kmc_pkg::SY_MDAT] &&
                            !q.cfg[kmc_pkg::CFG_MS_OFF]) begin
                  d.eng = kmc_pkg::E_RX;
                  d.ch = 1'b1;
                  d.sr = {1'b0, 10'h000};
                  d.nbit = 4'h1;
                  d.tmr = '0;
               end
            end
         end
         kmc_pkg::E_RX: begin
            if (ch_fall) begin
               d.sr = rx_sr;
               d.nbit = q.nbit + 4'h1;
               d.tmr = '0;
               if (q.nbit == LAST_BIT) begin
                  d.eng = kmc_pkg::E_IDLE;
                  // Bad framing or parity bytes are dropped silently
                  if (!rx_sr[0] && rx_sr[10] && (^rx_sr[9:1]) && !(!q.ch && kb_drop)) begin
                     fifo_in_valid = 1'b1;
                     fifo_in.mouse = q.ch;
                     fifo_in.data = rx_sr[8:1];
                  end
               end
            end else if (q.tmr == TMO_LAST) begin
               d.tmo = 1'b1;
               d.eng = kmc_pkg::E_IDLE;
            end else begin
               d.tmr = q.tmr + 18'h1;
            end
         end
         kmc_pkg::E_TX_INH: begin
            if (q.tmr == INH_LAST) begin
               d.eng = kmc_pkg::E_TX_BITS;
               d.tmr = '0;
               d.nbit = '0;
            end else begin
               d.tmr = q.tmr + 18'h1;
            end
         end
         kmc_pkg::E_TX_BITS: begin
            // Device clocks each bit; next bit goes out after each fall
            if (ch_fall) begin
               d.sr = {1'b1, q.sr[10:1]};
               d.nbit = q.nbit + 4'h1;
               d.tmr = '0;
               if (q.nbit == LAST_BIT) begin
                  d.eng = kmc_pkg::E_IDLE;
                  d.ibf = 1'b0;
               end
            end else if (q.tmr == TMO_LAST) begin
               d.tmo = 1'b1;
               d.eng = kmc_pkg::E_IDLE;
               d.ibf = 1'b0;
            end else begin
               d.tmr = q.tmr + 18'h1;
            end
         end
         kmc_pkg::E_PULSE: begin
            if (q.tmr == PULSE_LAST) begin
               d.pmask = '0;
               d.eng = kmc_pkg::E_IDLE;
               d.ibf = 1'b0;
            end else begin
               d.tmr = q.tmr + 18'h1;
            end
         end
         default: d.eng = kmc_pkg::E_IDLE;
      endcase

      // Host write overrides the buffer; a new write clears the timeout
      if (io_req.wr && (io_req.addr == kmc_pkg::PORT_CMD || io_req.addr == kmc_pkg::PORT_DATA)) begin
         d.ibuf = io_req.wdata;
         d.ibf = 1'b1;
         d.cmd_last = (io_req.addr == kmc_pkg::PORT_CMD);
         // Clears an old timeout only; one raised this cycle survives
         d.tmo = d.tmo & ~q.tmo;
      end

      // Output buffer fill: command answer first, else a device byte
      if (resp_v) begin
         d.obuf = resp_b;
         d.obf = 1'b1;
         d.aux = 1'b0;
      end else if (!d.obf && fifo_out_valid) begin
         fifo_out_ready = 1'b1;
         d.obuf = fifo_out.data;
         d.obf = 1'b1;
         d.aux = fifo_out.mouse;
         // Set after the read clear, so a new byte's interrupt is never lost
         if (fifo_out.mouse) begin
            d.irq_ms = q.cfg[kmc_pkg::CFG_MS_IRQ];
         end else begin
            d.irq_kb = q.cfg[kmc_pkg::CFG_KB_IRQ];
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         q <= '0;
         q.cfg <= kmc_pkg::CFG_RST;
         q.outp <= kmc_pkg::OUTP_RST;
         q.eng <= kmc_pkg::E_IDLE;
         q.await_st <= kmc_pkg::AW_NONE;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign io_rdata = q.rdata;
   assign keyboard_irq_line = q.irq_kb;
   assign mouse_irq_line = q.irq_ms;
   assign address_bit20_mask_n = q.outp[kmc_pkg::OP_A20] & ~q.pmask[kmc_pkg::OP_A20];
   assign cpu_reset_req_n = q.outp[kmc_pkg::OP_RST] & ~q.pmask[kmc_pkg::OP_RST];

   // Open-drain lines only ever pull low; clocks are held, never toggled
   assign kb_clk_o = 1'b0;
   assign ms_clk_o = 1'b0;
   assign kb_dat_o = 1'b0;
   assign ms_dat_o = 1'b0;
   // Full FIFO or pending host byte also holds clocks: back-pressure
   assign kb_clk_oe = q.cfg[kmc_pkg::CFG_KB_OFF] || (q.eng == kmc_pkg::E_TX_INH) ||
                      (busy && q.ch) || (q.eng == kmc_pkg::E_IDLE && (q.ibf || !fifo_in_ready));
   assign ms_clk_oe = q.cfg[kmc_pkg::CFG_MS_OFF] || (q.eng == kmc_pkg::E_TX_INH) ||
                      (busy && !q.ch) || (q.eng == kmc_pkg::E_IDLE && (q.ibf || !fifo_in_ready));
   assign kb_dat_oe = (q.eng == kmc_pkg::E_TX_BITS) && !q.ch && !q.sr[0];
   assign ms_dat_oe = (q.eng == kmc_pkg::E_TX_BITS) && q.ch && !q.sr[0];
endmodule

//--- tb/kmc_ctrl_chk.sv
// Checker of host port and link pin relations
`timescale 1ns/1ns
module kmc_ctrl_chk (
   input wire logic mclk,
   input wire logic resetn,
   input kmc_pkg::kmc_host_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic keyboard_irq_line,
   input wire logic kb_clk_oe,
   input wire logic ms_clk_oe,
   input wire logic kb_dat_oe,
   input wire logic kb_dat_o,
   input wire logic ms_dat_o
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Host side: read data, status and interrupt holding
   a_status_top_bit: assert property (io_req.rd && io_req.addr == 8'h64 |=> !io_rdata[7])
      else $error("status bit 7 set");
   a_rdata_stands: assert property (!io_req.rd |=> $stable(io_rdata))
      else $error("read data moved");
   a_irq_held: assert property (keyboard_irq_line && !(io_req.rd && io_req.addr == 8'h60) |=> keyboard_irq_line)
      else $error("irq dropped");
   a_irq_drop_cause: assert property ($fell(keyboard_irq_line) |-> $past(io_req.rd && io_req.addr == 8'h60))
      else $error("irq cleared without read");
   a_reset_outputs: assert property ($rose(resetn) |-> io_rdata == 8'h00 && !keyboard_irq_line)
      else $error("reset value wrong");
   // Link side: reset inhibit, open drain, other clock held
   a_clocks_held: assert property ($rose(resetn) |-> kb_clk_oe && ms_clk_oe)
      else $error("clocks not held");
   a_open_drain: assert property (kb_dat_o == 1'b0 && ms_dat_o == 1'b0)
      else $error("line driven high");
   a_tx_other_held: assert property (kb_dat_oe |-> ms_clk_oe)
      else $error("mouse free during send");
endmodule
bind kmc_ctrl kmc_ctrl_chk chk_u (.mclk(mclk), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
   .keyboard_irq_line(keyboard_irq_line), .kb_clk_oe(kb_clk_oe), .ms_clk_oe(ms_clk_oe),
   .kb_dat_oe(kb_dat_oe), .kb_dat_o(kb_dat_o), .ms_dat_o(ms_dat_o));

//--- tb/kmc_dev.sv
// Behavioural keyboard or mouse on an open-drain two-wire link
`timescale 1ns/1ns
module kmc_dev (
   input wire logic clk_oe,
   input wire logic dat_oe,
   output logic clk,
   output logic dat
);
   logic c = 1'b1;
   logic d = 1'b1;
   // Pull-ups: line low when either side pulls
   assign clk = c & ~clk_oe;
   assign dat = d & ~dat_oe;
   // One frame; clock stands high outside it
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ~^b, b, 1'b0};
      if (clk === 1'b0) return; // Inhibited: byte is not sent
      for (int i = 0; i < 11; i++) begin
         d = f[i];
         #31 c = 1'b0;
         #62 c = 1'b1;
         #32;
      end
      d = 1'b1;
   endtask
   // One host frame: waits for start with clock free, reads data before each fall
   task automatic recv(output logic [10:0] f);
      for (int t = 0; t < 400 && !(dat === 1'b0 && clk === 1'b1); t++) #10;
      for (int i = 0; i < 11; i++) begin
         #31 f[i] = dat;
         c = 1'b0;
         #62 c = 1'b1;
         #32;
      end
   endtask
endmodule

//--- tb/tb.sv
// Self-checking bench: command table, keyboard frames, inhibit, pulse
`timescale 1ns/1ns
module tb;
   logic mclk, resetn, pin, kirq, mirq, a20_n, rst_n, kco, kdo, mco, mdo, kc, kd, mc, md;
   logic [1:0] mode;
   logic [7:0] rdata, v;
   logic [10:0] fr;
   kmc_pkg::kmc_host_req_t req;
   int miscompares, checks_done, n;
   // Rows: command, expected response
   logic [15:0] rows [7] = '{16'h2070, 16'haa55, 16'ha900, 16'hab00, 16'hc083, 16'hd003, 16'he000};
   kmc_ctrl #(.INH_CYC(20), .TMO_CYC(2000)) dut_u (.mclk(mclk), .resetn(resetn), .io_req(req), .io_rdata(rdata),
      .keyboard_irq_line(kirq), .mouse_irq_line(mirq), .address_bit20_mask_n(a20_n), .cpu_reset_req_n(rst_n),
      .shared_inhibit_pin(pin), .inhibit_pin_mode(mode), .kb_clk_i(kc), .kb_clk_o(), .kb_clk_oe(kco),
      .kb_dat_i(kd), .kb_dat_o(), .kb_dat_oe(kdo), .ms_clk_i(mc), .ms_clk_o(), .ms_clk_oe(mco),
      .ms_dat_i(md), .ms_dat_o(), .ms_dat_oe(mdo));
   kmc_dev kb_u (.clk_oe(kco), .dat_oe(kdo), .clk(kc), .dat(kd));
   kmc_dev ms_u (.clk_oe(mco), .dat_oe(mdo), .clk(mc), .dat(md));
   // Byte compare
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Host write; one-clock strobe, then a fixed three-clock wait
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge mclk) #1 req.wr = 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Host read; data registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge mclk) #1 req.rd = 1'b0;
      d = rdata;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Main sequence
   initial begin
      miscompares = 0;
      checks_done = 0;
      resetn = 1'b0;
      pin = 1'b1;
      mode = 2'h0;
      req = '0;
      repeat (20) @(posedge mclk);
      #1 resetn = 1'b1;
      rd(8'h64, v); cmp(v, 8'h00);
      mode = 2'h1;
      for (int i = 0; i < 7; i++) begin
         wr(8'h64, rows[i][15:8]);
         rd(8'h64, v); cmp(v, 8'h19);
         rd(8'h60, v); cmp(v, rows[i][7:0]);
      end
      wr(8'h64, 8'h60); wr(8'h60, 8'h05);
      rd(8'h64, v); cmp(v, 8'h14);
      wr(8'h64, 8'h61); wr(8'h60, 8'h5a); wr(8'h64, 8'h2f);
      rd(8'h60, v); cmp(v, 8'h5a);
      kb_u.send(8'ha5);
      n = 0;
      while (kirq !== 1'b1 && n < 50) @(posedge mclk) #1 n++;
      cmp({7'h0, kirq}, 8'h01);
      rd(8'h64, v); cmp(v, 8'h1d);
      rd(8'h60, v); cmp(v, 8'ha5);
      cmp({7'h0, kirq}, 8'h00);
      pin = 1'b0;
      kb_u.send(8'h3c);
      repeat (20) @(posedge mclk);
      rd(8'h64, v); cmp(v, 8'h0c);
      pin = 1'b1;
      wr(8'h64, 8'hfe);
      n = 0;
      while (rst_n === 1'b0 && n < 2000) @(posedge mclk) #1 n++;
      cmp(8'(n > 590 && n < 2000), 8'h01);
      wr(8'h64, 8'hd1); wr(8'h60, 8'h01);
      cmp({6'h0, a20_n, rst_n}, 8'h01);
      wr(8'h60, 8'hf4);
      kb_u.recv(fr);
      cmp(fr[8:1], 8'hf4);
      cmp({5'h0, fr[10:9], fr[0]}, 8'h04);
      rd(8'h64, v); cmp(v, 8'h14);
      wr(8'h60, 8'h11);
      repeat (2100) @(posedge mclk);
      rd(8'h64, v); cmp(v, 8'h54);
      wr(8'h64, 8'hd4); wr(8'h60, 8'h5c);
      ms_u.recv(fr);
      cmp(fr[8:1], 8'h5c);
      cmp({5'h0, fr[10:9], fr[0]}, 8'h06);
      ms_u.send(8'h96);
      rd(8'h64, v); cmp(v, 8'h35);
      cmp({7'h0, mirq}, 8'h00);
      rd(8'h60, v); cmp(v, 8'h96);
      wr(8'h64, 8'had); cmp({6'h0, mco, kco}, 8'h01);
      wr(8'h64, 8'hae); wr(8'h64, 8'ha7); cmp({6'h0, mco, kco}, 8'h02);
      wr(8'h64, 8'ha8); cmp({6'h0, mco, kco}, 8'h00);
      results();
   end
endmodule
